/* File: src/oag_pkg.sv */
// package: operand address generator types, widths and encodings
package oag_pkg;

  localparam int OAG_DATA_W = 32;
  localparam int OAG_HALF_W = 16;
  localparam int OAG_CONST_W = 5;
  localparam int OAG_REG_IDX_W = 4;
  localparam int OAG_FSIZE_W = 6;
  localparam int OAG_NUM_REGS = 16;
  localparam logic [OAG_FSIZE_W-1:0] OAG_FSIZE_RST = 6'h20;
  localparam logic OAG_FEXT_RST = 1'b0;
  localparam logic OAG_FSEL_DEFAULT = 1'b0;
  localparam logic [OAG_DATA_W-1:0] OAG_ZERO = 32'h0000_0000;
  localparam int OAG_XY_X_LSB = 0;
  localparam int OAG_XY_Y_LSB = 16;

  // operand format of one side of an instruction
  typedef enum logic [3:0] {
    OAG_FMT_NONE = 4'h0,
    OAG_FMT_SHORT_IMM = 4'h1,
    OAG_FMT_LONG_IMM = 4'h2,
    OAG_FMT_CONST = 4'h3,
    OAG_FMT_ABS = 4'h4,
    OAG_FMT_REG = 4'h5,
    OAG_FMT_IND = 4'h6,
    OAG_FMT_IND_OFS = 4'h7,
    OAG_FMT_POSTINC = 4'h8,
    OAG_FMT_PREDEC = 4'h9,
    OAG_FMT_IND_XY = 4'hA
  } oag_fmt_t;

  typedef struct packed {
    logic file_b;
    logic [OAG_REG_IDX_W-1:0] idx;
  } oag_reg_t;

  // one decoded operand request
  typedef struct packed {
    oag_fmt_t fmt;
    oag_reg_t rsel;
    logic [OAG_DATA_W-1:0] word;
  } oag_opnd_t;

  // instruction request: source, destination and field select
  typedef struct packed {
    oag_opnd_t src;
    oag_opnd_t dst;
    logic plain_move;
    logic fsel_given;
    logic fsel;
  } oag_instr_t;

  // effective result for one operand
  typedef struct packed {
    logic is_mem;
    logic is_xy;
    logic [OAG_DATA_W-1:0] addr;
    logic [OAG_HALF_W-1:0] x;
    logic [OAG_HALF_W-1:0] y;
    logic [OAG_DATA_W-1:0] value;
    oag_reg_t rsel;
  } oag_ea_t;

  typedef enum logic [1:0] {
    OAG_ST_IDLE = 2'b00,
    OAG_ST_WB = 2'b01,
    OAG_ST_WB2 = 2'b11
  } oag_state_t;

endpackage : oag_pkg

/* File: src/oag_regfile.sv */
// register file pair holding address registers of both files
`timescale 1ns/1ns
`default_nettype none
module oag_regfile
  import oag_pkg::*;
#(
  parameter int NUM_REGS = OAG_NUM_REGS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire oag_reg_t rd_a_sel,
  output logic [OAG_DATA_W-1:0] rd_a_data,
  input wire oag_reg_t rd_b_sel,
  output logic [OAG_DATA_W-1:0] rd_b_data,
  input wire logic wr_en,
  input wire oag_reg_t wr_sel,
  input wire logic [OAG_DATA_W-1:0] wr_data
);

  if (NUM_REGS != (1 << OAG_REG_IDX_W)) begin : g_bad_num_regs
    $error("oag_regfile: NUM_REGS must match index width");
  end

  logic [OAG_DATA_W-1:0] mem [2*NUM_REGS];
  logic [OAG_DATA_W-1:0] next_rd_a_data;
  logic [OAG_DATA_W-1:0] next_rd_b_data;

  // ****************************************************************
  // read port selection
  // ****************************************************************
  always_comb begin
    next_rd_a_data = mem[{rd_a_sel.file_b, rd_a_sel.idx}];
    next_rd_b_data = mem[{rd_b_sel.file_b, rd_b_sel.idx}];
  end

  // read data come out of a register, so addresses settle one cycle on
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_a_data <= OAG_ZERO;
      rd_b_data <= OAG_ZERO;
    end else begin
      rd_a_data <= next_rd_a_data;
      rd_b_data <= next_rd_b_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[{wr_sel.file_b, wr_sel.idx}] <= wr_data;
    end
  end

endmodule // oag_regfile
`default_nettype wire

/* File: src/oag_ea_calc.sv */
// effective address arithmetic for one operand
`timescale 1ns/1ns
`default_nettype none
module oag_ea_calc
  import oag_pkg::*;
(
  input wire oag_fmt_t fmt,
  input wire logic [OAG_DATA_W-1:0] base,
  input wire logic [OAG_DATA_W-1:0] word,
  input wire logic [OAG_FSIZE_W-1:0] fsize,
  output logic [OAG_DATA_W-1:0] addr,
  output logic [OAG_DATA_W-1:0] wb_value,
  output logic wb_en
);

  logic [OAG_DATA_W-1:0] step;

  always_comb begin
    step = {{(OAG_DATA_W-OAG_FSIZE_W){1'b0}}, fsize};
    addr = base;
    wb_value = base;
    wb_en = 1'b0;
    case (fmt)
      OAG_FMT_ABS: addr = word;
      OAG_FMT_IND, OAG_FMT_IND_XY: addr = base;
      OAG_FMT_IND_OFS: addr = base + word;
      OAG_FMT_POSTINC: begin
        addr = base;
        wb_value = base + step;
        wb_en = 1'b1;
      end
      OAG_FMT_PREDEC: begin
        addr = base - step;
        wb_value = base - step;
        wb_en = 1'b1;
      end
      default: addr = base;
    endcase
  end

endmodule // oag_ea_calc
`default_nettype wire

/* File: src/oag_top.sv */
// operand decode and effective address generation for one instruction
//
// What this block does
// - short immediate is 16-bit signed source
// - long immediate is 32-bit signed source
// - 5-bit constant decoded as source operand
// - immediate source means register destination
// - register pair same file, except plain move
// - absolute address used directly for memory
// - register contents address source and destination
// - offset mode adds signed offset, base kept
// - postincrement uses register, then adds size
// - predecrement subtracts size, uses and keeps
// - field select one picks second settings
// - field select zero picks first settings
// - XY indirect uses register as XY
// - X in low half, Y high half
// - missing field select acts as zero
`timescale 1ns/1ns
`default_nettype none
module oag_top
  import oag_pkg::*;
#(
  parameter int FSIZE_W = OAG_FSIZE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire oag_instr_t instr,
  input wire logic [OAG_FSIZE_W-1:0] field_size_first,
  input wire logic field_extension_first,
  input wire logic [OAG_FSIZE_W-1:0] field_size_second,
  input wire logic field_extension_second,
  output logic result_valid,
  output logic illegal,
  output oag_ea_t src_ea,
  output oag_ea_t dst_ea,
  output logic [OAG_FSIZE_W-1:0] field_size,
  output logic field_extension,
  input wire logic reg_wr_en,
  input wire oag_reg_t reg_wr_sel,
  input wire logic [OAG_DATA_W-1:0] reg_wr_data
);

  if (FSIZE_W != OAG_FSIZE_W) begin : g_bad_fsize_w
    $error("oag_top: FSIZE_W must equal package field size width");
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic is_imm(input oag_fmt_t f);
    is_imm = (f == OAG_FMT_SHORT_IMM) || (f == OAG_FMT_LONG_IMM) ||
      (f == OAG_FMT_CONST);
  endfunction

  function automatic logic uses_reg(input oag_fmt_t f);
    uses_reg = (f == OAG_FMT_REG) || (f == OAG_FMT_IND) ||
      (f == OAG_FMT_IND_OFS) || (f == OAG_FMT_POSTINC) ||
      (f == OAG_FMT_PREDEC) || (f == OAG_FMT_IND_XY);
  endfunction

  function automatic logic is_mem(input oag_fmt_t f);
    is_mem = (f == OAG_FMT_ABS) || (f == OAG_FMT_IND) ||
      (f == OAG_FMT_IND_OFS) || (f == OAG_FMT_POSTINC) ||
      (f == OAG_FMT_PREDEC) || (f == OAG_FMT_IND_XY);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  oag_state_t state;
  oag_state_t next_state;
  oag_instr_t held;
  oag_instr_t next_held;

  logic [OAG_DATA_W-1:0] src_base;
  logic [OAG_DATA_W-1:0] dst_base;
  logic [OAG_FSIZE_W-1:0] sel_size;
  logic sel_ext;
  logic eff_fsel;
  logic [OAG_DATA_W-1:0] src_addr;
  logic [OAG_DATA_W-1:0] dst_addr;
  logic [OAG_DATA_W-1:0] src_wb;
  logic [OAG_DATA_W-1:0] dst_wb;
  logic src_wb_en;
  logic dst_wb_en;
  logic bad;
  logic same_ptr;
  logic wr_en;
  oag_reg_t wr_sel;
  logic [OAG_DATA_W-1:0] wr_data;
  logic two_wb;
  oag_reg_t pend_sel;
  oag_reg_t next_pend_sel;
  logic [OAG_DATA_W-1:0] pend_data;
  logic [OAG_DATA_W-1:0] next_pend_data;
  oag_ea_t next_src_ea;
  oag_ea_t next_dst_ea;
  logic next_result_valid;
  logic next_illegal;
  logic [OAG_FSIZE_W-1:0] next_field_size;
  logic next_field_extension;

  // register reads take one cycle, so a request is held for that cycle
  assign instr_ready = (state == OAG_ST_IDLE);

  always_comb begin
    next_state = state;
    next_held = held;
    next_pend_sel = pend_sel;
    next_pend_data = pend_data;
    case (state)
      OAG_ST_IDLE: begin
        if (instr_valid) begin
          next_held = instr;
          next_state = OAG_ST_WB;
        end
      end
      // two pointers to step but one write port: the destination update
      // waits a cycle, and no request is taken meanwhile
      OAG_ST_WB: begin
        next_state = OAG_ST_IDLE;
        if (two_wb) begin
          next_state = OAG_ST_WB2;
          next_pend_sel = held.dst.rsel;
          next_pend_data = dst_wb;
        end
      end
      OAG_ST_WB2: next_state = OAG_ST_IDLE;
      default: next_state = OAG_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= OAG_ST_IDLE;
      held <= '0;
      pend_sel <= '0;
      pend_data <= OAG_ZERO;
    end else begin
      state <= next_state;
      held <= next_held;
      pend_sel <= next_pend_sel;
      pend_data <= next_pend_data;
    end
  end

  oag_regfile u_regfile (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rd_a_sel(instr.src.rsel),
    .rd_a_data(src_base),
    .rd_b_sel(instr.dst.rsel),
    .rd_b_data(dst_base),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data)
  );

  // ****************************************************************
  // field selection
  // ****************************************************************
  always_comb begin
    eff_fsel = held.fsel_given ? held.fsel : OAG_FSEL_DEFAULT;
    if (eff_fsel) begin
      sel_size = field_size_second;
      sel_ext = field_extension_second;
    end else begin
      sel_size = field_size_first;
      sel_ext = field_extension_first;
    end
  end

  oag_ea_calc u_src_calc (
    .fmt(held.src.fmt),
    .base(src_base),
    .word(held.src.word),
    .fsize(sel_size),
    .addr(src_addr),
    .wb_value(src_wb),
    .wb_en(src_wb_en)
  );

  oag_ea_calc u_dst_calc (
    .fmt(held.dst.fmt),
    .base(dst_base),
    .word(held.dst.word),
    .fsize(sel_size),
    .addr(dst_addr),
    .wb_value(dst_wb),
    .wb_en(dst_wb_en)
  );

  // ****************************************************************
  // legality and pointer write-back
  // ****************************************************************
  always_comb begin
    bad = 1'b0;
    if (is_imm(held.src.fmt) && (held.dst.fmt != OAG_FMT_REG))
      bad = 1'b1;
    if ((held.src.fmt == OAG_FMT_REG) && (held.dst.fmt == OAG_FMT_REG) &&
        !held.plain_move &&
        (held.src.rsel.file_b != held.dst.rsel.file_b))
      bad = 1'b1;
    if (is_imm(held.dst.fmt) || (held.src.fmt == OAG_FMT_NONE))
      bad = 1'b1;
  end

  // when both sides step the same pointer, the source update wins and
  // only one write happens; a second write would double the step
  always_comb begin
    same_ptr = uses_reg(held.src.fmt) && uses_reg(held.dst.fmt) &&
      (held.src.rsel == held.dst.rsel);
    // distinct pointers on both sides each get their own update
    two_wb = !bad && src_wb_en && dst_wb_en && !same_ptr;
    wr_en = reg_wr_en;
    wr_sel = reg_wr_sel;
    wr_data = reg_wr_data;
    if ((state == OAG_ST_WB) && !bad) begin
      if (src_wb_en) begin
        wr_en = 1'b1;
        wr_sel = held.src.rsel;
        wr_data = src_wb;
      end else if (dst_wb_en) begin
        wr_en = 1'b1;
        wr_sel = held.dst.rsel;
        wr_data = dst_wb;
      end
    end
    if (state == OAG_ST_WB2) begin
      wr_en = 1'b1;
      wr_sel = pend_sel;
      wr_data = pend_data;
    end
  end

  // ****************************************************************
  // results
  // ****************************************************************
  always_comb begin
    next_src_ea = '0;
    next_dst_ea = '0;
    next_result_valid = 1'b0;
    next_illegal = 1'b0;
    next_field_size = field_size;
    next_field_extension = field_extension;
    if (state == OAG_ST_WB) begin
      next_result_valid = 1'b1;
      next_illegal = bad;
      next_field_size = sel_size;
      next_field_extension = sel_ext;
      case (held.src.fmt)
        OAG_FMT_SHORT_IMM: next_src_ea.value =
          {{OAG_HALF_W{held.src.word[OAG_HALF_W-1]}},
           held.src.word[OAG_HALF_W-1:0]};
        OAG_FMT_LONG_IMM: next_src_ea.value = held.src.word;
        OAG_FMT_CONST: next_src_ea.value =
          {{(OAG_DATA_W-OAG_CONST_W){1'b0}},
           held.src.word[OAG_CONST_W-1:0]};
        OAG_FMT_REG: next_src_ea.value = src_base;
        default: next_src_ea.value = OAG_ZERO;
      endcase
      next_src_ea.is_mem = is_mem(held.src.fmt);
      next_src_ea.addr = src_addr;
      next_src_ea.rsel = held.src.rsel;
      next_dst_ea.is_mem = is_mem(held.dst.fmt);
      next_dst_ea.addr = dst_addr;
      next_dst_ea.rsel = held.dst.rsel;
      next_dst_ea.value = dst_base;
      if (held.src.fmt == OAG_FMT_IND_XY) begin
        next_src_ea.is_xy = 1'b1;
        next_src_ea.x = src_base[OAG_XY_X_LSB +: OAG_HALF_W];
        next_src_ea.y = src_base[OAG_XY_Y_LSB +: OAG_HALF_W];
      end
      if (held.dst.fmt == OAG_FMT_IND_XY) begin
        next_dst_ea.is_xy = 1'b1;
        next_dst_ea.x = dst_base[OAG_XY_X_LSB +: OAG_HALF_W];
        next_dst_ea.y = dst_base[OAG_XY_Y_LSB +: OAG_HALF_W];
      end
      // a destination stepping the same pointer as a postincremented or predecremented
      // source must not see the stepped value twice
      if (same_ptr && src_wb_en && dst_wb_en)
        next_dst_ea.addr = src_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_ea <= '0;
      dst_ea <= '0;
      result_valid <= 1'b0;
      illegal <= 1'b0;
      field_size <= OAG_FSIZE_RST;
      field_extension <= OAG_FEXT_RST;
    end else begin
      src_ea <= next_src_ea;
      dst_ea <= next_dst_ea;
      result_valid <= next_result_valid;
      illegal <= next_illegal;
      field_size <= next_field_size;
      field_extension <= next_field_extension;
    end
  end

endmodule // oag_top
`default_nettype wire

/* File: tb/oag_top_props.sv */
// checker: port-level properties of the operand address generator
`timescale 1ns/1ns
`default_nettype none
module oag_top_props
  import oag_pkg::*;
#(
  parameter int FSIZE_W = OAG_FSIZE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire oag_instr_t instr,
  input wire logic [OAG_FSIZE_W-1:0] field_size_first,
  input wire logic [OAG_FSIZE_W-1:0] field_size_second,
  input wire logic result_valid,
  input wire logic illegal,
  input wire oag_ea_t src_ea,
  input wire oag_ea_t dst_ea,
  input wire logic [OAG_FSIZE_W-1:0] field_size
);
  // the taken request stays valid here until its result, as requests
  // come at most once every two cycles
  oag_instr_t held;
  logic ok;
  always_ff @(posedge ref_clk) begin
    if (instr_valid && instr_ready) begin
      held <= instr;
    end
  end
  assign ok = result_valid && !illegal;
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ********************************
  // assertions
  // ********************************
  take_answer_a: assert property (instr_valid && instr_ready
    |=> !instr_ready ##1 result_valid) else $error("result not timely");
  one_pulse_a: assert property (result_valid
    |=> !result_valid) else $error("result longer than one cycle");
  short_imm_a: assert property (ok && held.src.fmt == OAG_FMT_SHORT_IMM
    |-> src_ea.value == {{16{held.src.word[15]}}, held.src.word[15:0]})
    else $error("short immediate wrong");
  long_imm_a: assert property (ok && held.src.fmt == OAG_FMT_LONG_IMM
    |-> src_ea.value == held.src.word) else $error("long immediate wrong");
  const_val_a: assert property (ok && held.src.fmt == OAG_FMT_CONST
    |-> src_ea.value == {27'h0, held.src.word[4:0]})
    else $error("constant wrong");
  imm_dest_a: assert property (result_valid && held.src.fmt inside
    {OAG_FMT_SHORT_IMM, OAG_FMT_LONG_IMM, OAG_FMT_CONST}
    |-> illegal == (held.dst.fmt != OAG_FMT_REG)) else $error("imm dest");
  same_file_a: assert property (result_valid
    && held.src.fmt == OAG_FMT_REG
    && held.dst.fmt == OAG_FMT_REG |-> illegal == (!held.plain_move &&
    held.src.rsel.file_b != held.dst.rsel.file_b)) else $error("file pair");
  abs_addr_a: assert property (ok && held.dst.fmt == OAG_FMT_ABS
    |-> dst_ea.addr == held.dst.word) else $error("absolute address wrong");
  fsel_pick_a: assert property (ok
    |-> field_size == ((held.fsel_given && held.fsel) ?
    field_size_second : field_size_first)) else $error("field size wrong");
  fsize_hold_a: assert property (!result_valid
    |-> $stable(field_size)) else $error("field size moved");
  xy_mode_a: assert property (ok && held.dst.fmt == OAG_FMT_IND_XY
    |-> dst_ea.is_xy) else $error("xy not flagged");
  // two distinct stepped pointers keep the request side busy one more cycle
  ptr_pair_a: assert property (ok |-> instr_ready !=
    (held.src.fmt inside {OAG_FMT_POSTINC, OAG_FMT_PREDEC} &&
    held.dst.fmt inside {OAG_FMT_POSTINC, OAG_FMT_PREDEC} &&
    held.src.rsel != held.dst.rsel)) else $error("pointer pair write");
  cover property (ok && held.src.rsel == held.dst.rsel &&
    held.src.fmt == OAG_FMT_PREDEC && held.dst.fmt == OAG_FMT_POSTINC);
  cover property (ok && held.src.fmt == OAG_FMT_POSTINC);
  cover property (ok && held.src.fmt == OAG_FMT_SHORT_IMM);
  cover property (result_valid && illegal);
endmodule // oag_top_props
bind oag_top oag_top_props #(.FSIZE_W(FSIZE_W)) u_props (.ref_clk,
  .rst_n, .instr_valid, .instr_ready, .instr, .field_size_first,
  .field_size_second, .result_valid, .illegal, .src_ea, .dst_ea,
  .field_size);
`default_nettype wire

/* File: tb/oag_mem_model.sv */
// partner model: operand memory behind the generated addresses
`timescale 1ns/1ns
`default_nettype none
module oag_mem_model
  import oag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic result_valid,
  input wire logic illegal,
  input wire oag_ea_t src_ea,
  input wire oag_ea_t dst_ea,
  output int wr_count
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] data;
  initial wr_count = 0;
  // unwritten words read as the inverted address, never a stale value
  always @(posedge ref_clk) begin
    if (result_valid && !illegal) begin
      data = src_ea.value;
      if (src_ea.is_mem) begin
        data = mem.exists(src_ea.addr) ? mem[src_ea.addr]
          : ~src_ea.addr;
      end
      if (dst_ea.is_mem || dst_ea.is_xy) begin
        mem[dst_ea.addr] = data;
        wr_count++;
      end
    end
  end
endmodule // oag_mem_model
`default_nettype wire

/* File: tb/tb_oag_top.sv */
// testbench: operand formats, pointer updates and format checks
`timescale 1ns/1ns
`default_nettype none
module tb_oag_top
  import oag_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  oag_instr_t instr = '0;
  logic [5:0] fs_a = 6'h08;
  logic [5:0] fs_b = 6'h10;
  logic fe_a = 1'b0;
  logic fe_b = 1'b1;
  logic reg_wr_en = 1'b0;
  oag_reg_t reg_wr_sel = '0;
  logic [31:0] reg_wr_data = 32'h0;
  logic instr_ready, result_valid, illegal, field_extension;
  oag_ea_t src_ea, dst_ea;
  logic [5:0] field_size;
  int wr_count;
  int err_count = 0;
  int check_count = 0;
  int exp_wr = 0;
  logic [31:0] mdl_reg [32];
  logic [4:0] r;
  oag_fmt_t fm [10] = '{OAG_FMT_SHORT_IMM, OAG_FMT_LONG_IMM, OAG_FMT_CONST,
    OAG_FMT_REG, OAG_FMT_ABS, OAG_FMT_IND, OAG_FMT_IND_OFS,
    OAG_FMT_POSTINC, OAG_FMT_PREDEC, OAG_FMT_IND_XY};
  oag_fmt_t pf [6] = '{OAG_FMT_POSTINC, OAG_FMT_POSTINC, OAG_FMT_PREDEC,
    OAG_FMT_PREDEC, OAG_FMT_IND_OFS, OAG_FMT_IND};
  logic [1:0] pg [6] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h0, 2'h0};

  always #5 ref_clk = ~ref_clk;

  oag_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .field_size_first(fs_a),
    .field_extension_first(fe_a), .field_size_second(fs_b),
    .field_extension_second(fe_b), .result_valid(result_valid),
    .illegal(illegal), .src_ea(src_ea), .dst_ea(dst_ea),
    .field_size(field_size), .field_extension(field_extension),
    .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data));
  oag_mem_model u_mem (.ref_clk(ref_clk), .result_valid(result_valid),
    .illegal(illegal), .src_ea(src_ea), .dst_ea(dst_ea),
    .wr_count(wr_count));

  // ********************************
  // helpers
  // ********************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic imm(input oag_fmt_t f);
    return f inside {OAG_FMT_SHORT_IMM, OAG_FMT_LONG_IMM, OAG_FMT_CONST};
  endfunction
  function automatic oag_opnd_t op(oag_fmt_t f, logic [4:0] s,
                                   logic [31:0] w);
    return oag_opnd_t'({f, s, w});
  endfunction
  function automatic oag_instr_t ins(oag_opnd_t s, oag_opnd_t d, logic pm,
                                     logic [1:0] fg);
    return oag_instr_t'({s, d, pm, fg});
  endfunction
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_wr_sel <= oag_reg_t'(a);
    reg_wr_data <= d;
    @(negedge ref_clk);
    reg_wr_en <= 1'b0;
    mdl_reg[a] = d;
  endtask
  // checks one operand and steps the model's pointer as the device should
  task automatic chk_ea(input oag_opnd_t o, input oag_ea_t g,
                        input logic [5:0] fs);
    logic [31:0] v;
    v = mdl_reg[o.rsel];
    chk_flag(g.is_mem, o.fmt inside {[OAG_FMT_ABS:OAG_FMT_IND_XY]} &&
      o.fmt != OAG_FMT_REG);
    case (o.fmt)
      OAG_FMT_SHORT_IMM: chk_word(g.value,
        {{16{o.word[15]}}, o.word[15:0]});
      OAG_FMT_REG: chk_word(g.value, v);
      OAG_FMT_LONG_IMM: chk_word(g.value, o.word);
      OAG_FMT_CONST: chk_word(g.value, {27'h0, o.word[4:0]});
      OAG_FMT_ABS: chk_word(g.addr, o.word);
      OAG_FMT_IND: chk_word(g.addr, v);
      OAG_FMT_IND_OFS: chk_word(g.addr, v + o.word);
      OAG_FMT_POSTINC: begin
        chk_word(g.addr, v);
        mdl_reg[o.rsel] = v + {26'h0, fs};
      end
      OAG_FMT_PREDEC: begin
        mdl_reg[o.rsel] = v - {26'h0, fs};
        chk_word(g.addr, v - {26'h0, fs});
      end
      OAG_FMT_IND_XY: begin
        chk_flag(g.is_xy, 1'b1);
        chk_word({g.y, g.x}, v);
      end
      default: ;
    endcase
  endtask
  task automatic run(input oag_instr_t i);
    logic ill;
    logic sel;
    logic same;
    logic [31:0] keep;
    int n;
    sel = i.fsel_given && i.fsel;
    same = i.src.rsel == i.dst.rsel &&
      i.src.fmt inside {OAG_FMT_POSTINC, OAG_FMT_PREDEC} &&
      i.dst.fmt inside {OAG_FMT_POSTINC, OAG_FMT_PREDEC};
    ill = (imm(i.src.fmt) && i.dst.fmt != OAG_FMT_REG) || imm(i.dst.fmt) ||
      i.src.fmt == OAG_FMT_NONE || (i.src.fmt == OAG_FMT_REG &&
      i.dst.fmt == OAG_FMT_REG && !i.plain_move &&
      i.src.rsel.file_b != i.dst.rsel.file_b);
    @(negedge ref_clk);
    instr <= i;
    instr_valid <= 1'b1;
    @(negedge ref_clk);
    instr_valid <= 1'b0;
    n = 0;
    while (result_valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    chk_flag(result_valid, 1'b1);
    chk_flag(illegal, ill);
    if (!ill) begin
      keep = mdl_reg[i.src.rsel];
      chk_ea(i.src, src_ea, sel ? fs_b : fs_a);
      // one pointer stepped by both sides: one update, one shared address
      if (same) begin
        mdl_reg[i.src.rsel] = keep;
        chk_ea(i.src, dst_ea, sel ? fs_b : fs_a);
      end else begin
        chk_ea(i.dst, dst_ea, sel ? fs_b : fs_a);
      end
      chk_word({26'h0, field_size},
        {26'h0, sel ? fs_b : fs_a});
      chk_flag(field_extension, sel ? fe_b : fe_a);
      exp_wr += int'(i.dst.fmt inside {[OAG_FMT_ABS:OAG_FMT_IND_XY]} &&
        i.dst.fmt != OAG_FMT_REG);
    end
  endtask

  // ********************************
  // tests
  // ********************************
  initial begin
    void'($urandom(32'h9DF99B4E));
    fs_a = 6'($urandom);
    fs_b = 6'($urandom);
    repeat (20) @(negedge ref_clk);
    rst_n <= 1'b1;
    chk_flag(instr_ready, 1'b1);
    chk_word({26'h0, field_size}, 32'h20);
    for (int k = 0; k < 32; k++) wr_reg(5'(k), $urandom);
    $display("test reset_and_load done");
    for (int k = 0; k < 10; k++) begin
      r = 5'($urandom);
      run(ins(op(fm[k], {r[4], 1'b0, r[2:0]}, $urandom),
        op(OAG_FMT_REG, {r[4], 1'b1, r[2:0]}, 32'h0), 1'b0, 2'($urandom)));
      run(ins(op(OAG_FMT_REG, {r[4], 1'b0, r[2:0]}, 32'h0),
        op(fm[k], {r[4], 1'b1, r[2:0]}, $urandom), 1'b0, 2'($urandom)));
    end
    $display("test formats done");
    for (int k = 0; k < 6; k++) begin
      run(ins(op(pf[k], 5'h13, 32'hFFFF_FFF0),
        op(OAG_FMT_REG, 5'h1F, 32'h0), 1'b0, pg[k]));
    end
    $display("test pointers done");
    run(ins(op(OAG_FMT_REG, 5'h02, 0),
      op(OAG_FMT_REG, 5'h12, 0), 0, 0));
    run(ins(op(OAG_FMT_REG, 5'h02, 0),
      op(OAG_FMT_REG, 5'h12, 0), 1, 0));
    run(ins(op(OAG_FMT_NONE, 5'h02, 0), op(OAG_FMT_REG, 5'h03, 0), 0, 0));
    run(ins(op(OAG_FMT_POSTINC, 5'h13, 0),
      op(OAG_FMT_ABS, 0, 0), 0, 3));
    run(ins(op(OAG_FMT_LONG_IMM, 0, $urandom),
      op(OAG_FMT_ABS, 0, $urandom), 0, 0));
    run(ins(op(OAG_FMT_POSTINC, 5'h13, 0),
      op(OAG_FMT_PREDEC, 5'h04, 0), 0, 2));
    run(ins(op(OAG_FMT_PREDEC, 5'h13, 0),
      op(OAG_FMT_POSTINC, 5'h13, 0), 0, 3));
    run(ins(op(OAG_FMT_IND, 5'h13, 0),
      op(OAG_FMT_IND, 5'h04, 0), 0, 0));
    // the memory takes the last write one edge after the result is seen
    @(negedge ref_clk);
    chk_word(32'(wr_count), 32'(exp_wr));
    $display("test illegal_and_memory done");
    report_and_stop();
  end

  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule // tb_oag_top
`default_nettype wire
